// ===== rtl/llr_supervisor.sv
// Drive supervisor: low-charge speed cap, lift lockout and emergency reverse.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "llr_consts.svh"
// Notes on behaviour
// - Charge below low level caps vehicle speed.
// - Low level zero disables the cap.
// - Capped speed is programmable, 10 to 100 percent.
// - Source setting picks lockout pin or charge.
// - Disabled lockout output never goes active.
// - Internal lockout while charge below threshold.
// - Type 0 pulls low, type 1 opens.
// - Emergency reverse speed is capped.
// - Emergency reverse ends after its time limit.
// - Time limit zero means no limit.
// - Forward motion brakes to stop at decel rate.
// - Too-fast reverse slows down to the cap.
// - Reverse accelerates at the accel rate.
// - Braking current capped while braking.
// - Contact type sets belly switch polarity.
// - Interlock forces zero throttle until switch cycles.
// - Interlock switch debounced, 0 to 1000 ms.
module llr_supervisor #(
  parameter int TICK_CYCLES = `LLR_TICK_CYC
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // AXI4-Lite write address and data.
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // AXI4-Lite write response.
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read.
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Vehicle state.
  input wire llr_pkg::llr_pct_type charge_estimate_i,
  input wire llr_pkg::llr_speed_type throttle_i,
  input wire llr_pkg::llr_speed_type motor_speed_i,
  // Operator pins.
  input wire logic belly_switch_i,
  input wire logic interlock_switch_i,
  input wire logic ext_lockout_i,
  // Drive commands.
  output llr_pkg::llr_speed_type speed_cmd_o,
  output llr_pkg::llr_pct_type speed_cap_o,
  output llr_pkg::llr_pct_type brake_current_cap_o,
  output logic emergency_reverse_o,
  output logic throttle_inhibit_o,
  // Open-drain lift inhibit pin.
  output logic lockout_pin_o,
  output logic lockout_pin_oe_o
);
  import llr_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  logic [31:0] ctrl_reg;
  logic [31:0] level_reg;
  logic [31:0] rev_reg;
  logic [31:0] rate_reg;
  logic [31:0] deb_reg;
  llr_state_type state;
  llr_state_type next_state;
  llr_speed_type next_speed_cmd;
  llr_speed_type floor_q;
  logic [TW-1:0] tick_cnt;
  logic [6:0] ramp_cnt;
  logic [13:0] time_cnt;
  logic belly_q;
  logic seen_off;
  logic lock_active;
  logic [2:0] pins_s;
  logic ilk_clean;

  // Configuration fields.
  wire ext_src = ctrl_reg[`LLR_CTRL_EXT];
  wire out_en = ctrl_reg[`LLR_CTRL_OUTEN];
  wire out_type = ctrl_reg[`LLR_CTRL_TYPE];
  wire belly_nc = ctrl_reg[`LLR_CTRL_NC];
  wire ilk_en = ctrl_reg[`LLR_CTRL_ILK];
  wire [6:0] low_level = level_reg[`LLR_FA +: 7];
  wire [6:0] low_cap = level_reg[`LLR_FB +: 7];
  wire [6:0] lock_thr = level_reg[`LLR_FC +: 7];
  wire [6:0] rev_cap = rev_reg[`LLR_FA +: 7];
  wire [6:0] rev_time = rev_reg[`LLR_FB +: 7];
  wire [6:0] decel_rate = {1'b0, rate_reg[`LLR_FA +: 6]};
  wire [6:0] accel_rate = rate_reg[`LLR_FB +: 7];
  wire [6:0] brake_max = rate_reg[`LLR_FC +: 7];

  // Millisecond tick for all timed behaviour.
  wire tick = tick_cnt == TW'(TICK_CYCLES - 1);
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // Pin synchronisers and interlock debounce.
  llr_sync #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({belly_switch_i, interlock_switch_i, ext_lockout_i}),
    .sync_o(pins_s)
  );

  llr_debounce #(
    .DW(10)
  ) u_debounce (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick),
    .delay_i(deb_reg[9:0]),
    .raw_i(pins_s[1]),
    .clean_o(ilk_clean)
  );

  // Low-charge speed cap and lift lockout.
  wire low_active = (low_level != 7'h00) && (charge_estimate_i < low_level);
  wire [6:0] next_speed_cap = low_active ? low_cap : `LLR_FULL_SPEED;
  wire lock_int = charge_estimate_i < lock_thr;
  wire lock_trig = ext_src ? pins_s[0] : lock_int;
  wire next_lock_active = out_en & lock_trig;
  wire next_lock_oe = next_lock_active ^ out_type;

  // Belly switch press and emergency reverse start.
  wire belly_press = belly_nc ? ~pins_s[2] : pins_s[2];
  wire rev_start = belly_press & ~belly_q & (state == LLR_IDLE);
  wire signed [7:0] cap_floor = -$signed({1'b0, rev_cap});
  wire rev_fast = motor_speed_i < cap_floor;

  // Ramp stepping: one percent per rate-setting milliseconds.
  wire [6:0] rate_sel = (state == LLR_BRAKE) ? decel_rate : accel_rate;
  wire step = tick && (ramp_cnt + 7'h01 >= rate_sel);
  wire fwd_brake = (state == LLR_BRAKE) && (speed_cmd_o > 8'sh00);
  wire signed [7:0] tgt = fwd_brake ? 8'sh00 : floor_q;

  // Time limit runs only while the vehicle moves in reverse.
  wire [13:0] time_lim = {7'h00, rev_time} * `LLR_MS_PER_UNIT;
  wire limited = rev_time != 7'h00;
  wire expire = limited && (time_cnt >= time_lim);
  wire rev_end = expire || (!limited && !belly_press);

  // Normal drive: throttle, forced to zero by the interlock, clamped to the cap.
  wire signed [7:0] cap_s = $signed({1'b0, speed_cap_o});
  wire signed [7:0] thr = throttle_inhibit_o ? 8'sh00 : throttle_i;
  wire signed [7:0] thr_hi = (thr > cap_s) ? cap_s : thr;
  wire signed [7:0] thr_cl = (thr_hi < -cap_s) ? -cap_s : thr_hi;

  always_comb begin
    next_state = state;
    case (state)
      LLR_IDLE: begin
        if (rev_start) begin
          next_state = (motor_speed_i > 8'sh00 || rev_fast) ? LLR_BRAKE : LLR_RAMP;
        end
      end
      LLR_BRAKE: begin
        if (rev_end) begin
          next_state = LLR_IDLE;
        end else if (speed_cmd_o == 8'sh00 || speed_cmd_o == floor_q) begin
          next_state = LLR_RAMP;
        end
      end
      LLR_RAMP: begin
        if (rev_end) begin
          next_state = LLR_IDLE;
        end else if (speed_cmd_o == floor_q) begin
          next_state = LLR_HOLD;
        end
      end
      LLR_HOLD: begin
        if (rev_end) begin
          next_state = LLR_IDLE;
        end
      end
      default: begin
        next_state = LLR_IDLE;
      end
    endcase
  end

  always_comb begin
    next_speed_cmd = speed_cmd_o;
    if (state == LLR_IDLE) begin
      next_speed_cmd = rev_start ? motor_speed_i : thr_cl;
    end else if (step && speed_cmd_o < tgt) begin
      next_speed_cmd = speed_cmd_o + 8'sh01;
    end else if (step && speed_cmd_o > tgt) begin
      next_speed_cmd = speed_cmd_o - 8'sh01;
    end
  end

  wire [6:0] next_brake_cap = (next_state == LLR_BRAKE) ? brake_max : `LLR_FULL_CURRENT;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= LLR_IDLE;
      speed_cmd_o <= 8'sh00;
      floor_q <= 8'sh00;
      belly_q <= 1'b0;
      emergency_reverse_o <= 1'b0;
      brake_current_cap_o <= `LLR_FULL_CURRENT;
    end else begin
      state <= next_state;
      speed_cmd_o <= next_speed_cmd;
      floor_q <= rev_start ? cap_floor : floor_q;
      belly_q <= belly_press;
      emergency_reverse_o <= next_state != LLR_IDLE;
      brake_current_cap_o <= next_brake_cap;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ramp_cnt <= 7'h00;
      time_cnt <= 14'h0000;
    end else begin
      ramp_cnt <= (state == LLR_IDLE || step) ? 7'h00 : ramp_cnt + {6'h00, tick};
      if (state == LLR_IDLE) begin
        time_cnt <= 14'h0000;
      end else if (tick && motor_speed_i < 8'sh00 && !expire) begin
        time_cnt <= time_cnt + 14'h0001;
      end
    end
  end

  // Interlock: a new activation re-arms it even while it is being cleared.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      throttle_inhibit_o <= 1'b0;
      seen_off <= 1'b0;
    end else if (rev_start && ilk_en) begin
      throttle_inhibit_o <= 1'b1;
      seen_off <= 1'b0;
    end else if (!ilk_en) begin
      throttle_inhibit_o <= 1'b0;
      seen_off <= 1'b0;
    end else if (throttle_inhibit_o && !ilk_clean) begin
      seen_off <= 1'b1;
    end else if (seen_off && ilk_clean) begin
      throttle_inhibit_o <= 1'b0;
      seen_off <= 1'b0;
    end
  end

  // Speed cap and lift inhibit outputs.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      speed_cap_o <= `LLR_FULL_SPEED;
      lock_active <= 1'b0;
      lockout_pin_oe_o <= 1'b0;
    end else begin
      speed_cap_o <= next_speed_cap;
      lock_active <= next_lock_active;
      lockout_pin_oe_o <= next_lock_oe;
    end
  end
  assign lockout_pin_o = 1'b0;

  // AXI4-Lite slave: address and data are held until both are present.
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic rd_hit;

  assign s_axi_awready_o = ~aw_hold;
  assign s_axi_wready_o = ~w_hold;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  wire aw_take = s_axi_awvalid_i & ~aw_hold;
  wire w_take = s_axi_wvalid_i & ~w_hold;
  wire ar_take = s_axi_arvalid_i & ~s_axi_rvalid_o;
  wire wr_do = aw_hold & w_hold & ~s_axi_bvalid_o;
  wire wr_ctrl = wr_do && aw_addr == `LLR_ADDR_CTRL;
  wire wr_level = wr_do && aw_addr == `LLR_ADDR_LEVEL;
  wire wr_rev = wr_do && aw_addr == `LLR_ADDR_REV;
  wire wr_rate = wr_do && aw_addr == `LLR_ADDR_RATE;
  wire wr_deb = wr_do && aw_addr == `LLR_ADDR_DEB;
  wire wr_hit = wr_ctrl | wr_level | wr_rev | wr_rate | wr_deb;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{w_strb[b]}};
  end

  function automatic logic [31:0] llr_merge(input logic [31:0] old);
    return (old & ~wmask) | (w_data & wmask);
  endfunction : llr_merge

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `LLR_RESP_OK;
    end else begin
      if (aw_take) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_do) begin
        aw_hold <= 1'b0;
      end
      if (w_take) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_do) begin
        w_hold <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `LLR_RESP_OK : `LLR_RESP_ERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `LLR_RST_CTRL;
      level_reg <= `LLR_RST_LEVEL;
      rev_reg <= `LLR_RST_REV;
      rate_reg <= `LLR_RST_RATE;
      deb_reg <= `LLR_RST_DEB;
    end else begin
      ctrl_reg <= wr_ctrl ? llr_merge(ctrl_reg) & `LLR_MASK_CTRL : ctrl_reg;
      level_reg <= wr_level ? llr_merge(level_reg) & `LLR_MASK_LEVEL : level_reg;
      rev_reg <= wr_rev ? llr_merge(rev_reg) & `LLR_MASK_REV : rev_reg;
      rate_reg <= wr_rate ? llr_merge(rate_reg) & `LLR_MASK_RATE : rate_reg;
      deb_reg <= wr_deb ? llr_merge(deb_reg) & `LLR_MASK_DEB : deb_reg;
    end
  end

  wire [31:0] status = {8'h00, 1'b0, speed_cap_o, 1'b0, charge_estimate_i, 4'h0,
                        throttle_inhibit_o, emergency_reverse_o, lock_active, low_active};

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      `LLR_ADDR_CTRL: rd_val = ctrl_reg;
      `LLR_ADDR_LEVEL: rd_val = level_reg;
      `LLR_ADDR_REV: rd_val = rev_reg;
      `LLR_ADDR_RATE: rd_val = rate_reg;
      `LLR_ADDR_DEB: rd_val = deb_reg;
      `LLR_ADDR_STAT: rd_val = status;
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `LLR_RESP_OK;
    end else if (ar_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_val;
      s_axi_rresp_o <= rd_hit ? `LLR_RESP_OK : `LLR_RESP_ERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // A press is a synchronised pin level that differs from the contact's resting level.
  sequence s_rev_entry;
    (pins_s[2] != belly_nc) ##1 emergency_reverse_o;
  endsequence

  a_low_cap: assert property (
    low_active |=> speed_cap_o == $past(low_cap))
    else $error("Low charge did not apply the reduced cap.");
  a_low_off: assert property (
    low_level == 7'h00 |=> speed_cap_o == `LLR_FULL_SPEED)
    else $error("Zero low level still limited speed.");
  a_lock_src: assert property (
    out_en && ext_src |=> lock_active == $past(pins_s[0]))
    else $error("External lockout input not followed.");
  a_lock_int: assert property (
    out_en && !ext_src |=> lock_active == $past(charge_estimate_i < lock_thr))
    else $error("Internal lockout threshold not followed.");
  a_lock_off: assert property (
    !out_en |=> !lock_active)
    else $error("Disabled lockout output went active.");
  a_lock_pin: assert property (
    lockout_pin_oe_o == (lock_active ^ $past(out_type)))
    else $error("Lift inhibit pin in wrong state.");
  a_rev_enter: assert property (
    rev_start |-> s_rev_entry)
    else $error("Belly press did not start emergency reverse.");
  a_rev_cap: assert property (
    state == LLR_RAMP || state == LLR_HOLD |-> speed_cmd_o >= floor_q)
    else $error("Reverse command beyond emergency cap.");
  a_rev_limit: assert property (
    state != LLR_IDLE && expire |=> !emergency_reverse_o)
    else $error("Emergency reverse outlived its time limit.");
  a_rev_nolim: assert property (
    state != LLR_IDLE && !limited && belly_press |=> emergency_reverse_o)
    else $error("Emergency reverse ended with no time limit.");
  a_fwd_brake: assert property (
    rev_start && motor_speed_i > 8'sh00 |=> state == LLR_BRAKE)
    else $error("Forward motion was not braked.");
  a_brake_cur: assert property (
    state == LLR_BRAKE ##1 state == LLR_BRAKE |-> brake_current_cap_o == $past(brake_max))
    else $error("Braking current cap not applied.");
  a_ilk_force: assert property (
    throttle_inhibit_o && state == LLR_IDLE && !rev_start |=> speed_cmd_o == 8'sh00)
    else $error("Throttle not forced to zero by interlock.");
endmodule : llr_supervisor

// ===== rtl/llr_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef LLR_CONSTS_SVH
`define LLR_CONSTS_SVH
`define LLR_ADDR_CTRL 8'h00
`define LLR_ADDR_LEVEL 8'h04
`define LLR_ADDR_REV 8'h08
`define LLR_ADDR_RATE 8'h0c
`define LLR_ADDR_DEB 8'h10
`define LLR_ADDR_STAT 8'h14
`define LLR_CTRL_EXT 0
`define LLR_CTRL_OUTEN 1
`define LLR_CTRL_TYPE 2
`define LLR_CTRL_NC 3
`define LLR_CTRL_ILK 4
`define LLR_FA 0
`define LLR_FB 8
`define LLR_FC 16
`define LLR_MASK_CTRL 32'h0000_001f
`define LLR_MASK_LEVEL 32'h007f_7f7f
`define LLR_MASK_REV 32'h0000_7f7f
`define LLR_MASK_RATE 32'h007f_7f3f
`define LLR_MASK_DEB 32'h0000_03ff
`define LLR_RST_CTRL 32'h0000_0000
`define LLR_RST_LEVEL 32'h000a_320a
`define LLR_RST_REV 32'h0000_3232
`define LLR_RST_RATE 32'h003c_140a
`define LLR_RST_DEB 32'h0000_0064
`define LLR_RESP_OK 2'h0
`define LLR_RESP_ERR 2'h2
`define LLR_FULL_SPEED 7'h64
`define LLR_FULL_CURRENT 7'h7f
`define LLR_CLK_MHZ 200
`define LLR_TICK_US 1000
`define LLR_TICK_CYC (`LLR_TICK_US * `LLR_CLK_MHZ)
`define LLR_MS_PER_UNIT 14'h0064
`endif

// ===== rtl/llr_pkg.sv
// Types shared by the drive supervisor.
package llr_pkg;
  typedef logic [6:0] llr_pct_type;
  typedef logic signed [7:0] llr_speed_type;
  typedef enum logic [3:0] {
    LLR_IDLE = 4'b0001,
    LLR_BRAKE = 4'b0010,
    LLR_RAMP = 4'b0100,
    LLR_HOLD = 4'b1000
  } llr_state_type;
endpackage : llr_pkg

// ===== rtl/llr_sync.sv
// Two-flop synchroniser for pin levels.
`timescale 1ns/1ps
module llr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Levels.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage <= '0;
      sync_o <= '0;
    end else begin
      stage <= async_i;
      sync_o <= stage;
    end
  end
endmodule : llr_sync

// ===== rtl/llr_debounce.sv
// Debounce filter for a synchronised switch level, timed in millisecond ticks.
`timescale 1ns/1ps
module llr_debounce #(
  parameter int DW = 10
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Timing.
  input wire logic tick_i,
  input wire logic [DW-1:0] delay_i,
  // Switch level.
  input wire logic raw_i,
  output logic clean_o
);
  logic [DW-1:0] cnt;
  wire differ = raw_i != clean_o;
  wire settle = differ && (cnt >= delay_i);
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      clean_o <= 1'b0;
    end else begin
      clean_o <= settle ? raw_i : clean_o;
      cnt <= (!differ || settle) ? '0 : (tick_i ? cnt + 1'b1 : cnt);
    end
  end
  a_deb_settled: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $changed(clean_o) |-> $past(raw_i) == clean_o && $past(cnt) >= $past(delay_i))
    else $error("Switch level passed before its debounce delay.");
endmodule : llr_debounce

// ===== verif/llr_vehicle_model.sv
// Operator switches, lift pump contactor and drive motor stage.
`timescale 1ns/1ps
module llr_vehicle_model (
  // Clock.
  input wire logic ref_clk_i,
  // Bench commands.
  input wire logic press_i,
  input wire logic nc_i,
  input wire logic ilk_closed_i,
  input wire logic hold_i,
  input wire llr_pkg::llr_speed_type hold_speed_i,
  // Device side.
  input wire llr_pkg::llr_speed_type speed_cmd_i,
  input wire logic lockout_pin_i,
  input wire logic lockout_pin_oe_i,
  output llr_pkg::llr_speed_type motor_speed_o,
  output logic belly_switch_o,
  output logic interlock_switch_o,
  output logic pump_line_o
);
  import llr_pkg::*;
  // A normally closed contact opens when pressed.
  assign belly_switch_o = nc_i ? !press_i : press_i;
  assign interlock_switch_o = ilk_closed_i;
  // The contactor line has a pull-up; the device can only pull it low.
  assign pump_line_o = lockout_pin_oe_i ? lockout_pin_i : 1'b1;
  // The motor follows the command a cycle late unless the bench pins its speed.
  always_ff @(posedge ref_clk_i) begin
    motor_speed_o <= hold_i ? hold_speed_i : speed_cmd_i;
  end
endmodule : llr_vehicle_model

// ===== verif/llr_supervisor_tb.sv
// Self-checking bench for the drive supervisor.
`timescale 1ns/1ps
`include "llr_consts.svh"
module llr_supervisor_tb;
  import llr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd_data;
  logic awr, wr_r, bv, arr, rv, er, inhibit, pin, pin_oe, belly, ilk_pin, pump;
  logic [1:0] bresp, rresp;
  llr_pct_type charge = 7'h50;
  llr_pct_type cap, brake_cap;
  llr_speed_type throttle = 8'sh00, hold_speed = 8'sh00, cap_lim = -8'sd100;
  llr_speed_type motor, speed_cmd;
  logic press = 1'b0, nc = 1'b0, ilk = 1'b1, hold = 1'b0, ext_req = 1'b0;
  int err_count = 0, checked = 0, cyc = 0, n, m;
  logic [4:0] lk_ctrl [7] = '{5'h02, 5'h02, 5'h06, 5'h06, 5'h00, 5'h03, 5'h03};
  logic [6:0] lk_chg [7] = '{7'd10, 7'd40, 7'd10, 7'd40, 7'd10, 7'd10, 7'd40};
  logic lk_ext [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic lk_exp [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [31:0] rst_exp [7] = '{`LLR_RST_CTRL, `LLR_RST_LEVEL, `LLR_RST_REV, `LLR_RST_RATE,
    `LLR_RST_DEB, 32'h0064_5000, 32'h0};

  always #2.5 ref_clk_i = ~ref_clk_i;

  llr_supervisor #(.TICK_CYCLES(10)) DUT (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd_data),
    .s_axi_rresp_o(rresp), .charge_estimate_i(charge), .throttle_i(throttle),
    .motor_speed_i(motor), .belly_switch_i(belly), .interlock_switch_i(ilk_pin),
    .ext_lockout_i(ext_req), .speed_cmd_o(speed_cmd), .speed_cap_o(cap),
    .brake_current_cap_o(brake_cap), .emergency_reverse_o(er),
    .throttle_inhibit_o(inhibit), .lockout_pin_o(pin), .lockout_pin_oe_o(pin_oe)
  );

  llr_vehicle_model partner (
    .ref_clk_i(ref_clk_i), .press_i(press), .nc_i(nc), .ilk_closed_i(ilk),
    .hold_i(hold), .hold_speed_i(hold_speed), .speed_cmd_i(speed_cmd),
    .lockout_pin_i(pin), .lockout_pin_oe_i(pin_oe), .motor_speed_o(motor),
    .belly_switch_o(belly), .interlock_switch_o(ilk_pin), .pump_line_o(pump)
  );

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask : tick

  // Handshakes are judged from values that stand through the coming rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_rs);
    logic aw_t, w_t, b_t;
    logic [1:0] rs;
    @(posedge ref_clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge ref_clk_i);
      aw_t = awv && awr;
      w_t = wv && wr_r;
      b_t = bv;
      rs = bresp;
      @(posedge ref_clk_i);
      if (aw_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
      if (b_t) break;
    end
    bry <= 1'b0;
    chk("bresp", 32'(exp_rs), 32'(rs));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_rs);
    logic ar_t, r_t;
    logic [1:0] rs;
    logic [31:0] d;
    @(posedge ref_clk_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge ref_clk_i);
      ar_t = arv && arr;
      r_t = rv;
      rs = rresp;
      d = rd_data;
      @(posedge ref_clk_i);
      if (ar_t) arv <= 1'b0;
      if (r_t) break;
    end
    rry <= 1'b0;
    chk("rresp", 32'(exp_rs), 32'(rs));
    chk("rdata", exp, d);
  endtask : rd

  // The reverse command must never run faster than the allowed figure.
  always @(negedge ref_clk_i) begin
    if (er === 1'b1 && speed_cmd < cap_lim) begin
      err_count++;
      $display("[FAIL] speed_cmd expected >= %0d seen %0d", cap_lim, speed_cmd);
    end
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] run time expected < 20000 seen %0d", cyc);
      results();
    end
  end

  initial begin
    tick(5);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), rst_exp[i], i == 6 ? 2'h2 : 2'h0);
    wr(8'h18, 32'h1, `LLR_RESP_ERR);
    wr(`LLR_ADDR_LEVEL, 32'hff94_b29e, `LLR_RESP_OK);
    rd(`LLR_ADDR_LEVEL, 32'h0014_321e, `LLR_RESP_OK);
    charge <= 7'd25;
    throttle <= 8'sd80;
    tick(6);
    chk("cap", 32'd50, 32'(cap));
    chk("speed_cmd", 32'd50, 32'(speed_cmd));
    charge <= 7'd40;
    tick(6);
    chk("cap", 32'd100, 32'(cap));
    wr(`LLR_ADDR_LEVEL, 32'h0014_3200, `LLR_RESP_OK);
    charge <= 7'd5;
    tick(6);
    chk("cap", 32'd100, 32'(cap));
    wr(`LLR_ADDR_LEVEL, 32'h0014_321e, `LLR_RESP_OK);
    throttle <= 8'sd0;
    for (int i = 0; i < 7; i++) begin
      wr(`LLR_ADDR_CTRL, 32'(lk_ctrl[i]), `LLR_RESP_OK);
      charge <= lk_chg[i];
      ext_req <= lk_ext[i];
      tick(8);
      chk("pump_line", 32'(lk_exp[i]), 32'(pump));
    end
    ext_req <= 1'b0;
    wr(`LLR_ADDR_CTRL, 32'h0, `LLR_RESP_OK);
    wr(`LLR_ADDR_REV, 32'h0000_0114, `LLR_RESP_OK);
    wr(`LLR_ADDR_RATE, 32'h0028_0302, `LLR_RESP_OK);
    hold <= 1'b1;
    hold_speed <= 8'sd10;
    cap_lim <= -8'sd20;
    tick(4);
    press <= 1'b1;
    for (n = 0; n < 10 && er !== 1'b1; n++) tick(1);
    chk("er", 32'h1, 32'(er));
    hold <= 1'b0;
    tick(2);
    chk("brake_cap", 32'd40, 32'(brake_cap));
    for (n = 0; n < 400 && !(motor < 0); n++) tick(1);
    chk("decel_time", 32'h1, 32'(n > 180 && n < 235));
    chk("brake_cap", 32'd127, 32'(brake_cap));
    for (m = 0; m < 900 && speed_cmd !== -8'sd20; m++) tick(1);
    chk("accel_time", 32'h1, 32'(m > 560 && m < 580));
    for (n = m; n < 1300 && er === 1'b1; n++) tick(1);
    chk("er_time", 32'h1, 32'(n > 980 && n < 1035));
    press <= 1'b0;
    wr(`LLR_ADDR_REV, 32'h0000_0014, `LLR_RESP_OK);
    wr(`LLR_ADDR_DEB, 32'h2, `LLR_RESP_OK);
    cap_lim <= -8'sd50;
    nc <= 1'b1;
    wr(`LLR_ADDR_CTRL, 32'h18, `LLR_RESP_OK);
    tick(20);
    chk("er", 32'h0, 32'(er));
    hold <= 1'b1;
    hold_speed <= -8'sd50;
    throttle <= 8'sd30;
    tick(2);
    press <= 1'b1;
    for (n = 0; n < 10 && er !== 1'b1; n++) tick(1);
    chk("er", 32'h1, 32'(er));
    tick(2);
    chk("inhibit", 32'h1, 32'(inhibit));
    for (n = 0; n < 900 && speed_cmd !== -8'sd20; n++) tick(1);
    chk("slow_time", 32'h1, 32'(n > 570 && n < 665));
    tick(1500);
    chk("er", 32'h1, 32'(er));
    press <= 1'b0;
    hold <= 1'b0;
    tick(10);
    chk("er", 32'h0, 32'(er));
    chk("speed_cmd", 32'h0, 32'(speed_cmd));
    ilk <= 1'b0;
    tick(10);
    ilk <= 1'b1;
    tick(40);
    chk("inhibit", 32'h1, 32'(inhibit));
    ilk <= 1'b0;
    tick(40);
    ilk <= 1'b1;
    tick(40);
    chk("inhibit", 32'h0, 32'(inhibit));
    chk("speed_cmd", 32'd30, 32'(speed_cmd));
    rd(`LLR_ADDR_CTRL, 32'h18, `LLR_RESP_OK);
    results();
  end
endmodule : llr_supervisor_tb
